// File: logic/bridge_pkg.sv
package bridge_pkg;
   // ==============================
   // sequencer shape
   localparam int SEQ_W = 5;
   // ==============================
   // timing
   localparam int CORE_PERIOD_NS = 20;
   localparam int TIMEBASE_PERIOD_NS = 100;
   localparam int TIMEBASE_CORE_CYCLES = TIMEBASE_PERIOD_NS / CORE_PERIOD_NS;
   localparam int GAP_NS = 200;
   localparam int GAP_TICKS = GAP_NS / TIMEBASE_PERIOD_NS;
   localparam int MAX_BYTE_TICKS = 8;
   localparam int REF_BYTE_TICKS = 6;
   localparam int SYNC_TICKS = 4;
   // ==============================
   // register map
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
   localparam logic [APB_AW-1:0] STATUS_OFS = 8'h04;
   localparam logic [APB_AW-1:0] COUNT_OFS = 8'h08;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam int STAT_SEQ_LSB = 0;
   localparam int STAT_ACK_BIT = 5;
   localparam int STAT_CLAIM_BIT = 6;
   localparam int STAT_EN_BIT = 7;
   localparam int COUNT_W = 16;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
endpackage

// File: logic/seq_if.sv
`timescale 1ns/1ps
interface seq_if import bridge_pkg::*; ();
   logic tick;
   logic run;
   logic granted;
   logic [SEQ_W-1:0] bits;
   logic ack;
   logic ack_n;
   modport seq_side(input tick, input run, input granted,
      output bits, output ack, output ack_n);
   modport user_side(output tick, output run, output granted,
      input bits, input ack, input ack_n);
endinterface

// File: logic/gray_sequencer.sv
`timescale 1ns/1ps
module gray_sequencer import bridge_pkg::*; (
   input wire logic i_clk,
   input wire logic i_rst_n,
   seq_if.seq_side sq
);
   logic [SEQ_W-1:0] bits_q;
   logic [SEQ_W-1:0] bits_d;
   logic ack_q;
   logic ack_n_q;
   logic en;

   // ==============================
   // next state of the gray count
   assign en = sq.run & sq.granted;
   always_comb begin
      bits_d[0] = ~bits_q[0];
      bits_d[1] = bits_q[1] ^ ~bits_q[0];
      bits_d[2] = bits_q[2] ^ (bits_q[0] & bits_q[1]);
      bits_d[3] = bits_q[3] ^ (bits_q[0] & ~bits_q[1] & bits_q[2]);
      bits_d[4] = bits_q[4] ^ (bits_q[0] & ~bits_q[1] & ~bits_q[2]);
   end

   // ==============================
   // state register, stepped on timebase edges only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bits_q <= '0;
      end else if (sq.tick) begin
         bits_q <= en ? bits_d : '0;
      end
   end

   // ==============================
   // grant acknowledge, both polarities
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
         ack_n_q <= 1'b1;
      end else if (sq.tick) begin
         ack_q <= sq.granted;
         ack_n_q <= ~sq.granted;
      end
   end

   assign sq.bits = bits_q;
   assign sq.ack = ack_q;
   assign sq.ack_n = ack_n_q;

   // ==============================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_seq_clear: assert property (sq.tick && !en |=> bits_q == '0)
      else $error("sequencer not cleared without enable");
   a_bit0_run: assert property (sq.tick && en |=> bits_q[0] != $past(bits_q[0]))
      else $error("bit 0 did not toggle");
   a_bit2_step: assert property (sq.tick && en |=>
      bits_q[2] == ($past(bits_q[2]) ^ ($past(bits_q[0]) & $past(bits_q[1]))))
      else $error("bit 2 wrong step");
   a_bit3_step: assert property (sq.tick && en && bits_q[2:0] == 3'h5 |=>
      bits_q[3] != $past(bits_q[3]))
      else $error("bit 3 did not toggle");
   a_bit4_step: assert property (sq.tick && en && bits_q[2:0] == 3'h3 |=>
      bits_q[4] == $past(bits_q[4]))
      else $error("bit 4 moved unexpectedly");
   a_ack_pair: assert property (sq.tick |=> ack_q == $past(sq.granted) && ack_n_q == !ack_q)
      else $error("grant acknowledge not registered");
endmodule

// File: logic/lan_dma_to_byte_bus_bridge.sv
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module lan_dma_to_byte_bus_bridge import bridge_pkg::*; (
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [APB_AW-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic I_CTRL_TIMEBASE,
   input wire logic I_CTRL_HOLD_REQ,
   input wire logic I_DMA_DATA_STROBE,
   output logic O_DMA_DATA_STROBE,
   output logic O_DMA_DATA_STROBE_OE,
   input wire logic I_CTRL_READ,
   output logic O_CTRL_READ,
   output logic O_CTRL_READ_OE,
   input wire logic I_CTRL_READY,
   output logic O_CTRL_READY,
   output logic O_CTRL_READY_OE,
   input wire logic I_CTRL_BYTE_MODE,
   input wire logic I_CTRL_ALE,
   input wire logic I_CTRL_A0,
   input wire logic [7:0] I_CTRL_DATA_LO,
   output logic [7:0] O_CTRL_DATA_LO,
   output logic O_CTRL_DATA_LO_OE,
   input wire logic I_CPU_BUS_GRANTED,
   output logic O_CPU_BUS_CLAIM,
   output logic O_GRANT_ACK_SYNC_LOW,
   output logic O_GRANT_ACK_SYNC_HIGH,
   output logic [SEQ_W-1:0] O_SEQUENCER_BITS,
   input wire logic I_MEMORY_CYCLE_STROBE,
   output logic O_MEMORY_CYCLE_STROBE,
   output logic O_MEMORY_CYCLE_STROBE_OE,
   input wire logic I_IO_CYCLE_STROBE,
   input wire logic I_OPCODE_FETCH_CYCLE,
   input wire logic I_CPU_READ,
   output logic O_CPU_READ,
   output logic O_CPU_READ_OE,
   input wire logic I_CPU_WRITE,
   output logic O_CPU_WRITE,
   output logic O_CPU_WRITE_OE,
   input wire logic [8:0] I_CPU_ADDR,
   input wire logic [7:0] I_CPU_DATA,
   output logic [7:0] O_CPU_DATA,
   output logic O_CPU_DATA_OE,
   input wire logic [7:0] I_MEM_DATA,
   output logic O_CPU_WAIT_RELEASE,
   output logic O_BUS_BYTE_SELECT_OUT,
   output logic O_BUS_BYTE_SELECT_OUT_OE,
   output logic O_LAN_CTRL_SELECT,
   output logic O_LOW_PORT_READ_STROBE,
   output logic O_LOW_PORT_WRITE_STROBE,
   output logic O_LOW_PORT_OUTPUT_ENABLE,
   output logic O_DMA_LOW_BYTE_WRITE_GATE,
   output logic O_DMA_LOW_BYTE_READ_GATE,
   output logic O_DMA_HIGH_BYTE_WRITE_GATE,
   output logic O_DMA_HIGH_BYTE_READ_GATE,
   output logic O_LOW_BYTE_CAPTURE_GATE
);
   seq_if sq();
   logic tb_q;
   logic dma;
   logic [SEQ_W-1:0] b;
   logic gap, io_hit, cs_d, ready_d, a0b_d, memory_cycle_strobe_d, rd_d, wr_d, cap_d;
   logic lprd_d, lpwr_d, lpoe_d, dma_low_byte_write_gate_d, wrhi_d;
   logic ctrl_en_q;
   logic strobe_q;
   logic [COUNT_W-1:0] count_q;
   logic [7:0] hold_q;
   logic [7:0] cap_q;
   logic setup;
   logic hit;
   logic [31:0] rdata_d;

   // ==============================
   // timebase edge and sequencer
   // timebase is treated as a plain input; the core clock must be at least
   // twice as fast, which the fixed 5:1 ratio gives
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         tb_q <= 1'b0;
      end else begin
         tb_q <= I_CTRL_TIMEBASE;
      end
   end

   assign sq.tick = I_CTRL_TIMEBASE & ~tb_q;
   assign sq.run = I_DMA_DATA_STROBE;
   assign sq.granted = I_CPU_BUS_GRANTED;

   gray_sequencer u_seq (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RESET_N),
      .sq(sq)
   );

   assign dma = sq.ack;
   assign b = sq.bits;
   assign O_GRANT_ACK_SYNC_HIGH = sq.ack;
   assign O_GRANT_ACK_SYNC_LOW = sq.ack_n;
   assign O_SEQUENCER_BITS = sq.bits;

   // ==============================
   // strobe and decode terms
   always_comb begin
      gap = b[2] & b[3] & ~b[4];
      io_hit = ~dma & ~I_OPCODE_FETCH_CYCLE & I_IO_CYCLE_STROBE & (&I_CPU_ADDR[8:6]);
      cs_d = io_hit & I_CPU_ADDR[0];
      lprd_d = io_hit & ~I_CPU_ADDR[0] & I_CPU_READ;
      lpwr_d = io_hit & ~I_CPU_ADDR[0] & I_CPU_WRITE;
      lpoe_d = cs_d & I_CPU_WRITE;
      if (I_CTRL_BYTE_MODE) begin
         ready_d = ~I_CTRL_ALE;
      end else begin
         ready_d = I_DMA_DATA_STROBE & ((~b[1] & ~b[2] & b[3]) | (~b[2] & b[3] & ~b[4]) | b[4]);
      end
      a0b_d = I_CTRL_BYTE_MODE ? I_CTRL_A0 : (b[3] | b[4]);
      memory_cycle_strobe_d = I_DMA_DATA_STROBE & ~gap;
      rd_d = I_CTRL_READ & memory_cycle_strobe_d;
      if (I_CTRL_BYTE_MODE) begin
         wr_d = ~I_CTRL_READ & I_DMA_DATA_STROBE & (|b[4:2]);
      end else begin
         wr_d = ~I_CTRL_READ & I_DMA_DATA_STROBE & ((b[2] & ~b[3] & ~b[4])
            | (~b[1] & ~b[2] & b[3]) | (~b[2] & b[3] & b[4]));
      end
      cap_d = dma & ~a0b_d & rd_d;
      // low byte via buffer, high via transceiver
      // on a write only the addressed byte lane opens; a read opens both read gates
      dma_low_byte_write_gate_d = dma & ~a0b_d & wr_d;
      wrhi_d = dma & a0b_d & wr_d;
   end

   // ==============================
   // bus request and wait release
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_CPU_BUS_CLAIM <= 1'b0;
         O_CPU_WAIT_RELEASE <= 1'b0;
      end else begin
         // registered claim, keeps metastability off the cpu pin
         O_CPU_BUS_CLAIM <= I_CTRL_HOLD_REQ & ctrl_en_q;
         O_CPU_WAIT_RELEASE <= I_MEMORY_CYCLE_STROBE | (~cs_d & I_IO_CYCLE_STROBE)
            | (cs_d & I_CTRL_READY);
      end
   end

   // ==============================
   // controller-facing strobes
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_CTRL_READ <= 1'b0;
         O_CTRL_READ_OE <= 1'b0;
         O_DMA_DATA_STROBE <= 1'b0;
         O_DMA_DATA_STROBE_OE <= 1'b0;
         O_CTRL_READY <= 1'b0;
         O_CTRL_READY_OE <= 1'b0;
      end else begin
         // io mode drives direction and strobe
         O_CTRL_READ <= ~dma & I_CPU_READ;
         O_CTRL_READ_OE <= ~dma;
         O_DMA_DATA_STROBE <= ~dma & (I_CPU_READ | I_CPU_WRITE);
         O_DMA_DATA_STROBE_OE <= ~dma;
         O_CTRL_READY <= dma & ready_d;
         O_CTRL_READY_OE <= dma;
      end
   end

   // ==============================
   // memory strobes toward the byte bus
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_MEMORY_CYCLE_STROBE <= 1'b0;
         O_CPU_READ <= 1'b0;
         O_CPU_WRITE <= 1'b0;
         O_BUS_BYTE_SELECT_OUT <= 1'b0;
         O_MEMORY_CYCLE_STROBE_OE <= 1'b0;
         O_CPU_READ_OE <= 1'b0;
         O_CPU_WRITE_OE <= 1'b0;
         O_BUS_BYTE_SELECT_OUT_OE <= 1'b0;
      end else begin
         O_MEMORY_CYCLE_STROBE <= dma & memory_cycle_strobe_d;
         O_CPU_READ <= dma & rd_d;
         O_CPU_WRITE <= dma & wr_d;
         O_BUS_BYTE_SELECT_OUT <= dma & a0b_d;
         O_MEMORY_CYCLE_STROBE_OE <= dma;
         O_CPU_READ_OE <= dma;
         O_CPU_WRITE_OE <= dma;
         O_BUS_BYTE_SELECT_OUT_OE <= dma;
      end
   end

   // ==============================
   // data path control
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_LAN_CTRL_SELECT <= 1'b0;
         O_LOW_PORT_READ_STROBE <= 1'b0;
         O_LOW_PORT_WRITE_STROBE <= 1'b0;
         O_LOW_PORT_OUTPUT_ENABLE <= 1'b0;
         O_DMA_LOW_BYTE_WRITE_GATE <= 1'b0;
         O_DMA_LOW_BYTE_READ_GATE <= 1'b0;
         O_DMA_HIGH_BYTE_WRITE_GATE <= 1'b0;
         O_DMA_HIGH_BYTE_READ_GATE <= 1'b0;
         O_LOW_BYTE_CAPTURE_GATE <= 1'b0;
      end else begin
         O_LAN_CTRL_SELECT <= cs_d;
         O_LOW_PORT_READ_STROBE <= lprd_d;
         O_LOW_PORT_WRITE_STROBE <= lpwr_d;
         O_LOW_PORT_OUTPUT_ENABLE <= lpoe_d;
         O_DMA_LOW_BYTE_WRITE_GATE <= dma_low_byte_write_gate_d;
         O_DMA_LOW_BYTE_READ_GATE <= dma & rd_d;
         O_DMA_HIGH_BYTE_WRITE_GATE <= wrhi_d;
         O_DMA_HIGH_BYTE_READ_GATE <= dma & rd_d;
         O_LOW_BYTE_CAPTURE_GATE <= cap_d;
      end
   end

   // ==============================
   // holding register and capture latch
   // the holding register isolates cpu byte pairs from dma traffic between them
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         hold_q <= 8'h00;
         cap_q <= 8'h00;
      end else begin
         // low byte parked first on write
         if (lpwr_d) begin
            hold_q <= I_CPU_DATA;
         end else if (cs_d & I_CPU_READ) begin
            hold_q <= I_CTRL_DATA_LO;
         end
         // first byte of a word read
         if (cap_d) begin
            cap_q <= I_MEM_DATA;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_CTRL_DATA_LO <= 8'h00;
         O_CTRL_DATA_LO_OE <= 1'b0;
         O_CPU_DATA <= 8'h00;
         O_CPU_DATA_OE <= 1'b0;
      end else begin
         // held byte beside the high byte
         O_CTRL_DATA_LO <= lpoe_d ? hold_q : cap_q;
         // both bytes together on second read
         O_CTRL_DATA_LO_OE <= lpoe_d | (dma & rd_d & a0b_d & ~I_CTRL_BYTE_MODE);
         O_CPU_DATA <= hold_q;
         O_CPU_DATA_OE <= lprd_d;
      end
   end

   // ==============================
   // transfer counter
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         strobe_q <= 1'b0;
         count_q <= COUNT_RESET;
      end else begin
         strobe_q <= I_DMA_DATA_STROBE & dma;
         if (strobe_q & ~(I_DMA_DATA_STROBE & dma)) begin
            count_q <= count_q + 16'h0001;
         end
      end
   end

   // ==============================
   // apb slave, one wait-free access phase
   assign setup = I_PSEL & ~I_PENABLE;
   always_comb begin
      hit = 1'b1;
      rdata_d = 32'h0000_0000;
      unique case (I_PADDR)
         CTRL_OFS: rdata_d[CTRL_EN_BIT] = ctrl_en_q;
         STATUS_OFS: begin
            rdata_d[STAT_SEQ_LSB +: SEQ_W] = b;
            rdata_d[STAT_ACK_BIT] = dma;
            rdata_d[STAT_CLAIM_BIT] = O_CPU_BUS_CLAIM;
            rdata_d[STAT_EN_BIT] = ctrl_en_q;
         end
         COUNT_OFS: rdata_d[COUNT_W-1:0] = count_q;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_PREADY <= 1'b0;
         O_PRDATA <= 32'h0000_0000;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY <= setup;
         O_PSLVERR <= setup & ~hit;
         if (setup) begin
            O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rdata_d;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ctrl_en_q <= CTRL_EN_RESET;
      end else if (I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & (I_PADDR == CTRL_OFS)) begin
         ctrl_en_q <= I_PWDATA[CTRL_EN_BIT];
      end
   end

   // ==============================
   // checks
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);

   logic [4:0] word_ticks_q;
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         word_ticks_q <= 5'h00;
      end else if (!I_DMA_DATA_STROBE || !dma || I_CTRL_BYTE_MODE || O_CTRL_READY) begin
         word_ticks_q <= 5'h00;
      end else if (sq.tick && word_ticks_q != 5'h1F) begin
         word_ticks_q <= word_ticks_q + 5'h01;
      end
   end

   a_claim_copy: assert property ($rose(I_CTRL_HOLD_REQ) && ctrl_en_q |=> O_CPU_BUS_CLAIM)
      else $error("bus claim did not follow hold request");
   a_io_direction: assert property (!dma |=> O_CTRL_READ_OE &&
      O_DMA_DATA_STROBE == ($past(I_CPU_READ) | $past(I_CPU_WRITE)))
      else $error("io strobe not derived from cpu strobes");
   a_word_ready: assert property (dma && !I_CTRL_BYTE_MODE && !I_DMA_DATA_STROBE
      |=> !O_CTRL_READY)
      else $error("word ready without data strobe");
   a_wait_term: assert property (I_MEMORY_CYCLE_STROBE |=> O_CPU_WAIT_RELEASE)
      else $error("wait release missing on memory cycle");
   a_byte_sel: assert property (dma && !I_CTRL_BYTE_MODE && b[4] |=> O_BUS_BYTE_SELECT_OUT)
      else $error("high byte not selected in second half");
   a_memory_cycle_strobe_gap: assert property (dma && gap |=> !O_MEMORY_CYCLE_STROBE && !O_CPU_READ)
      else $error("memory strobe active inside gap");
   a_write_state: assert property (O_CPU_WRITE |-> $past(!I_CTRL_READ && I_DMA_DATA_STROBE))
      else $error("memory write outside write transfer");
   a_ctrl_select: assert property (O_LAN_CTRL_SELECT |-> $past(!dma && I_CPU_ADDR[0]
      && !I_OPCODE_FETCH_CYCLE))
      else $error("controller selected outside its window");
   a_low_port: assert property (lpwr_d |=> O_LOW_PORT_WRITE_STROBE ##1 hold_q == $past(I_CPU_DATA, 2))
      else $error("holding register not loaded");
   a_low_gates: assert property (O_DMA_LOW_BYTE_WRITE_GATE |-> !O_BUS_BYTE_SELECT_OUT)
      else $error("low write gate on odd address");
   a_capture: assert property (O_LOW_BYTE_CAPTURE_GATE |-> O_CPU_READ && O_MEMORY_CYCLE_STROBE_OE)
      else $error("capture outside dma read");
   a_word_time: assert property (word_ticks_q <= 5'(MAX_BYTE_TICKS))
      else $error("word transfer exceeded timebase budget");
   a_float: assert property (!dma [*2] |-> !O_MEMORY_CYCLE_STROBE_OE && !O_CTRL_READY_OE)
      else $error("dma outputs driven without acknowledge");
endmodule

// File: sim/host_mem_model.sv
`timescale 1ns/1ps
// ==========
// host cpu and byte memory
module host_mem_model #(
   parameter int GRANT_DLY = 3
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_claim,
   output logic o_granted,
   input wire logic i_mem_rd,
   input wire logic i_hi_sel,
   output logic [7:0] o_mem_data
);
   int wait_q;
   // grant comes late so the claim has to stay up
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_q <= 0;
         o_granted <= 1'b0;
      end else begin
         wait_q <= i_claim ? wait_q + 1 : 0;
         o_granted <= i_claim && (wait_q >= GRANT_DLY);
      end
   end
   // an idle memory bus toggles rather than keep stale data
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_data <= 8'h00;
      end else if (i_mem_rd) begin
         o_mem_data <= i_hi_sel ? 8'hB2 : 8'hA1;
      end else begin
         o_mem_data <= ~o_mem_data;
      end
   end
endmodule

// File: sim/lan_dma_to_byte_bus_bridge_bench.sv
`timescale 1ns/1ps
module lan_dma_to_byte_bus_bridge_bench import bridge_pkg::*;;
   logic clk, rst_n, psel, pen, pwr, tb, hreq, dma_data_strobe, crd, bm, ale, a0, gnt;
   logic fetch, io, memory_cycle_strobe, rd, wr, rdy, prdy, perr, e, claim, ackl, ackh, bsel, gap;
   logic das_o, das_oe, crd_o, crd_oe, rdy_o, rdy_oe, mem_o, mem_oe, rd_o, rd_oe, wr_o, wr_oe;
   logic csel, lrd, lwr, loe, wrel, wgl, wgh, rgl, rgh, cap, cdoe;
   logic das_w, crd_w, rdy_w, rd_w, wr_w, memory_cycle_strobe_w;
   logic [7:0] paddr, mdat, dlo, cdat;
   logic [8:0] addr;
   logic [31:0] pwd, prd, r;
   logic [4:0] sq, prev, s;
   int err_count, cmp_count, cycles, tbc;
   // ==========
   // io rows: fetch io memory_cycle_strobe rd wr ready, address, then select lrd lwr loe release
   localparam logic [19:0] IO_ROWS [7] = '{{6'b010101, 9'h1C1, 5'b10001},
      {6'b010011, 9'h1C0, 5'b00101}, {6'b010011, 9'h1C1, 5'b10011},
      {6'b010101, 9'h1C0, 5'b01001}, {6'b110101, 9'h1C1, 5'b00001},
      {6'b001101, 9'h0C1, 5'b00001}, {6'b010100, 9'h1C1, 5'b10000}};
   localparam logic [4:0] WSEQ [8] = '{5'h03, 5'h06, 5'h05, 5'h0C, 5'h0F, 5'h0A, 5'h09, 5'h18};
   // shared pins resolve from whoever has the enable
   assign das_w = das_oe ? das_o : dma_data_strobe;
   assign crd_w = crd_oe ? crd_o : crd;
   assign rdy_w = rdy_oe ? rdy_o : rdy;
   assign rd_w = rd_oe ? rd_o : rd;
   assign wr_w = wr_oe ? wr_o : wr;
   assign memory_cycle_strobe_w = mem_oe ? mem_o : memory_cycle_strobe;
   lan_dma_to_byte_bus_bridge dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd),
      .O_PREADY(prdy), .O_PSLVERR(perr), .I_CTRL_TIMEBASE(tb), .I_CTRL_HOLD_REQ(hreq),
      .I_DMA_DATA_STROBE(das_w), .O_DMA_DATA_STROBE(das_o), .O_DMA_DATA_STROBE_OE(das_oe),
      .I_CTRL_READ(crd_w), .O_CTRL_READ(crd_o), .O_CTRL_READ_OE(crd_oe),
      .I_CTRL_READY(rdy_w), .O_CTRL_READY(rdy_o), .O_CTRL_READY_OE(rdy_oe),
      .I_CTRL_BYTE_MODE(bm), .I_CTRL_ALE(ale), .I_CTRL_A0(a0), .I_CTRL_DATA_LO(8'h3C),
      .O_CTRL_DATA_LO(dlo), .O_CTRL_DATA_LO_OE(), .I_CPU_BUS_GRANTED(gnt),
      .O_CPU_BUS_CLAIM(claim), .O_GRANT_ACK_SYNC_LOW(ackl), .O_GRANT_ACK_SYNC_HIGH(ackh),
      .O_SEQUENCER_BITS(sq), .I_MEMORY_CYCLE_STROBE(memory_cycle_strobe_w), .O_MEMORY_CYCLE_STROBE(mem_o),
      .O_MEMORY_CYCLE_STROBE_OE(mem_oe), .I_IO_CYCLE_STROBE(io),
      .I_OPCODE_FETCH_CYCLE(fetch), .I_CPU_READ(rd_w), .O_CPU_READ(rd_o),
      .O_CPU_READ_OE(rd_oe), .I_CPU_WRITE(wr_w), .O_CPU_WRITE(wr_o), .O_CPU_WRITE_OE(wr_oe),
      .I_CPU_ADDR(addr), .I_CPU_DATA(8'h5A), .O_CPU_DATA(cdat), .O_CPU_DATA_OE(cdoe),
      .I_MEM_DATA(mdat), .O_CPU_WAIT_RELEASE(wrel), .O_BUS_BYTE_SELECT_OUT(bsel),
      .O_BUS_BYTE_SELECT_OUT_OE(), .O_LAN_CTRL_SELECT(csel), .O_LOW_PORT_READ_STROBE(lrd),
      .O_LOW_PORT_WRITE_STROBE(lwr), .O_LOW_PORT_OUTPUT_ENABLE(loe),
      .O_DMA_LOW_BYTE_WRITE_GATE(wgl), .O_DMA_LOW_BYTE_READ_GATE(rgl),
      .O_DMA_HIGH_BYTE_WRITE_GATE(wgh), .O_DMA_HIGH_BYTE_READ_GATE(rgh),
      .O_LOW_BYTE_CAPTURE_GATE(cap));
   host_mem_model #(.GRANT_DLY(3)) cpu (.i_clk(clk), .i_rst_n(rst_n), .i_claim(claim),
      .o_granted(gnt), .i_mem_rd(rd_w), .i_hi_sel(bsel), .o_mem_data(mdat));
   always #10 clk = ~clk;
   // free-running timebase, one period every five core cycles
   always @(posedge clk) begin
      tbc <= (tbc == 4) ? 0 : tbc + 1;
      tb <= (tbc < 2);
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (prdy !== 1'b1);
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      cyc(1);
   endtask
   // wait for the sequencer to step, then let the strobes settle
   task nxt;
      int n;
      prev = sq;
      n = 0;
      while (sq === prev && n < 20) begin
         cyc(1);
         n++;
      end
      cyc(2);
   endtask
   initial begin
      clk = 0;
      rst_n = 0;
      {psel, pen, pwr, hreq, dma_data_strobe, crd, bm, ale, a0, fetch, io, memory_cycle_strobe, rd, wr, rdy} = '0;
      {paddr, pwd, addr, tb, tbc, cycles, err_count, cmp_count} = '0;
      cyc(10);
      chk(ackl, 1);
      chk(claim, 0);
      rst_n <= 1'b1;
      cyc(1);
      apb(0, CTRL_OFS, 0);
      chk(r[CTRL_EN_BIT], CTRL_EN_RESET);
      apb(0, 8'h0C, 0);
      chk({e, r[30:0]}, 32'h80000000);
      // low byte written before the odd high-byte write
      for (int i = 0; i < 7; i++) begin
         {fetch, io, memory_cycle_strobe, rd, wr, rdy, addr} <= IO_ROWS[i][19:5];
         cyc(3);
         chk(das_o, rd | wr);
         chk(crd_o, rd);
         chk({csel, lrd, lwr, loe, wrel}, IO_ROWS[i][4:0]);
         if (IO_ROWS[i][1]) chk(dlo, 8'h5A);
         chk(cdoe, IO_ROWS[i][3]);
         if (IO_ROWS[i][3]) chk(cdat, 8'h5A);
      end
      {fetch, io, memory_cycle_strobe, rd, wr, rdy} <= '0;
      apb(1, CTRL_OFS, 0);
      hreq <= 1'b1;
      cyc(4);
      chk(claim, 0);
      apb(1, CTRL_OFS, 1);
      cyc(4);
      chk(claim, 1);
      cyc(30);
      chk({ackh, ackl, mem_oe}, 3'b101);
      apb(0, STATUS_OFS, 0);
      chk({r[STAT_CLAIM_BIT], r[STAT_ACK_BIT]}, 2'b11);
      for (int d = 0; d < 2; d++) begin
         crd <= (d == 0);
         dma_data_strobe <= 1'b1;
         for (int i = 0; i < 8; i++) begin
            nxt();
            s = WSEQ[i];
            gap = s[2] & s[3] & !s[4];
            chk(sq, s);
            chk(mem_o, !gap);
            chk(rd_o, (d == 0) & !gap);
            chk(wr_o, (d == 1) & (s[2] & !s[3] & !s[4] | s[3] & !s[1] & !s[2]
               | s[3] & s[4] & !s[2]));
            chk(bsel, s[3] | s[4]);
            chk(rdy_o, s[3] & !s[1] & !s[2] | s[3] & !s[2] & !s[4] | s[4]);
            if (!gap) chk(rgl, d == 0);
            if (!gap) chk({rgh, cap}, {d == 0, (d == 0) & !(s[3] | s[4])});
            if ((d == 0) & (s[3] | s[4]) & !gap) chk(dlo, 8'hA1);
         end
         dma_data_strobe <= 1'b0;
         cyc(12);
         chk(sq, 0);
      end
      {bm, a0} <= 2'b11;
      dma_data_strobe <= 1'b1;
      nxt();
      chk({rdy_o, bsel, wgl, wr_o}, 4'b1100);
      nxt();
      chk({wr_o, wgh}, 2'b11);
      {a0, ale} <= 2'b01;
      cyc(3);
      chk({rdy_o, bsel, wgl}, 3'b001);
      dma_data_strobe <= 1'b0;
      hreq <= 1'b0;
      cyc(30);
      chk({claim, ackh, ackl, mem_oe}, 4'b0010);
      apb(0, COUNT_OFS, 0);
      chk(r[COUNT_W-1:0], 3);
      end_of_test();
   end
endmodule
